// >>> rtl/lxb_pkg.sv
// package: register map, field layout, reset values and carriers for the lane crossbar block
package lxb_pkg;
  localparam int LANES = 8;
  localparam int LINKS = 2;
  localparam int LANE_W = 32;
  localparam int BUF_DEPTH = 8;
  localparam int BUF_AW = 3;
  localparam int PTR_W = BUF_AW + 1;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int VAL_W = 5;
  localparam int SEL_W = 3;
  localparam int MAX_DELAY = 31;
  localparam int LINK1_FIRST_LANE = 4;
  localparam int SEL_LO_LSB = 0;
  localparam int SEL_HI_LSB = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_LATENCY [LINKS] = '{10'h302, 10'h303};
  localparam logic [ADDR_W-1:0] OFF_DELAY [LINKS] = '{10'h304, 10'h305};
  localparam logic [ADDR_W-1:0] OFF_READOUT [LINKS] = '{10'h306, 10'h307};
  localparam logic [ADDR_W-1:0] OFF_MAP [LANES/2] = '{10'h308, 10'h309, 10'h30a, 10'h30b};
  localparam logic [ADDR_W-1:0] OFF_FULL = 10'h30c;

  // reset values and padding
  localparam logic [VAL_W-1:0] DELAY_RST = 5'h00;
  localparam logic [VAL_W-1:0] READOUT_RST = 5'h06;
  localparam logic [VAL_W-1:0] LATENCY_RST = 5'h00;
  localparam logic [VAL_W-1:0] VAL_ONE = 5'h01;
  localparam logic [VAL_W-1:0] VAL_MAX = 5'h1f;
  localparam logic [2:0] RSV3 = 3'h0;
  localparam logic [1:0] RSV2 = 2'h0;
  localparam logic [DATA_W-1:0] RD_NONE = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_FULL_XOR = 4'h8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } lxb_reg_req_t;

  typedef struct packed {
    logic valid;
    logic [LANE_W-1:0] data;
  } lxb_lane_t;
endpackage

// >>> rtl/lxb_top.sv
// lane crossbar, per-lane buffers and lmfc-timed read-out release with latency report
//
// Behaviour
// - each link reports 5-bit latency from its delayed global lmfc to its deframer lmfc.
// - each link delays the global lmfc by its 5-bit frame count, reset zero.
// - lane buffers release words at the rx lmfc position set per link, reset six.
// - logical lane n takes data from the physical lane its 3-bit field selects.
// - after reset logical lane n maps to physical lane n.
// - 8-bit read-only full vector, bit x high while lane x buffer is full.
// - link 1 and its settings act only when two-link mode is selected.
`timescale 1ns/1ps
`default_nettype none
module lxb_top
  import lxb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire lxb_reg_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // mode and multiframe timing
  input wire logic two_link_select,
  input wire logic global_lmfc,
  input wire logic [LINKS-1:0] deframer_lmfc,
  // lanes
  input wire lxb_lane_t serial_input_lane [LANES],
  output lxb_lane_t logical_lane [LANES],
  output logic [LANES-1:0] lane_buffer_full
);

  logic [MAX_DELAY-1:0] glmfc_hist_r;
  logic [MAX_DELAY-1:0] glmfc_hist_nxt;
  logic [VAL_W-1:0] delay_r [LINKS];
  logic [VAL_W-1:0] readout_r [LINKS];
  logic [VAL_W-1:0] rx_cnt_r [LINKS];
  logic [VAL_W-1:0] lat_cnt_r [LINKS];
  logic [VAL_W-1:0] latency_r [LINKS];
  logic [LINKS-1:0] rx_seen_r;
  logic [LINKS-1:0] release_r;
  logic [LINKS-1:0] link_on;
  logic [LINKS-1:0] lmfc_dly;
  logic [SEL_W-1:0] sel_r [LANES];
  logic [DATA_W-1:0] map_rd [LANES/2];
  logic [DATA_W-1:0] rd_link [LINKS];
  logic [DATA_W-1:0] rd_map;
  logic [DATA_W-1:0] rd_mux;

  // global lmfc history, one tap per frame cycle
  assign glmfc_hist_nxt = {glmfc_hist_r[MAX_DELAY-2:0], global_lmfc};

  always_ff @(posedge clk)
  begin
    if (srst)
      glmfc_hist_r <= '0;
    else
      glmfc_hist_r <= glmfc_hist_nxt;
  end

  genvar l;
  generate
    for (l = 0; l < LINKS; l++)
    begin : g_link
      logic wr_delay;
      logic wr_readout;
      logic [VAL_W-1:0] tap;
      logic at_readout;
      assign link_on[l] = (l == 0) || two_link_select;
      assign wr_delay = reg_req.wr && (reg_req.addr == OFF_DELAY[l]);
      assign wr_readout = reg_req.wr && (reg_req.addr == OFF_READOUT[l]);
      assign tap = delay_r[l] - VAL_ONE;
      // delay zero passes the live pulse through
      assign lmfc_dly[l] = (delay_r[l] == DELAY_RST) ? global_lmfc : glmfc_hist_r[tap];
      assign at_readout = rx_seen_r[l] && (rx_cnt_r[l] == readout_r[l]);
      assign rd_link[l] = (reg_req.addr == OFF_LATENCY[l]) ? {RSV3, latency_r[l]} :
                          (reg_req.addr == OFF_DELAY[l]) ? {RSV3, delay_r[l]} :
                          (reg_req.addr == OFF_READOUT[l]) ? {RSV3, readout_r[l]} : RD_NONE;

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          delay_r[l] <= DELAY_RST;
          readout_r[l] <= READOUT_RST;
        end
        else
        begin
          if (wr_delay)
            delay_r[l] <= reg_req.wdata[VAL_W-1:0];
          if (wr_readout)
            readout_r[l] <= reg_req.wdata[VAL_W-1:0];
        end
      end

      // receive lmfc phase, aligned to the delayed global lmfc
      always_ff @(posedge clk)
      begin
        if (srst || !link_on[l])
        begin
          rx_cnt_r[l] <= '0;
          rx_seen_r[l] <= 1'b0;
          release_r[l] <= 1'b0;
        end
        else
        begin
          rx_cnt_r[l] <= lmfc_dly[l] ? '0 : rx_cnt_r[l] + VAL_ONE;
          if (lmfc_dly[l])
            rx_seen_r[l] <= 1'b1;
          if (at_readout)
            release_r[l] <= 1'b1;
        end
      end

      // cycles from delayed global lmfc to this link's deframer lmfc
      always_ff @(posedge clk)
      begin
        if (srst || !link_on[l])
        begin
          lat_cnt_r[l] <= '0;
          latency_r[l] <= LATENCY_RST;
        end
        else
        begin
          // start at one so the value captured equals the cycle distance between the pulses
          if (lmfc_dly[l])
            lat_cnt_r[l] <= VAL_ONE;
          else if (lat_cnt_r[l] != VAL_MAX)
            lat_cnt_r[l] <= lat_cnt_r[l] + VAL_ONE;
          if (deframer_lmfc[l])
            latency_r[l] <= lmfc_dly[l] ? '0 : lat_cnt_r[l];
        end
      end
    end
  endgenerate

  genvar n;
  generate
    for (n = 0; n < LANES; n++)
    begin : g_lane
      localparam int FLD = (n % 2 == 1) ? SEL_HI_LSB : SEL_LO_LSB;
      localparam logic [SEL_W-1:0] SEL_RST = SEL_W'(n);
      logic [LANE_W-1:0] mem [BUF_DEPTH];
      logic [PTR_W-1:0] wr_ptr_r;
      logic [PTR_W-1:0] rd_ptr_r;
      logic wr_map;
      logic lk;
      logic full;
      logic empty;
      logic push;
      logic pop;
      lxb_lane_t src;
      assign wr_map = reg_req.wr && (reg_req.addr == OFF_MAP[n/2]);
      assign src = serial_input_lane[sel_r[n]];
      // lanes above the split belong to link 1 only in two-link mode
      assign lk = two_link_select && (n >= LINK1_FIRST_LANE);
      assign full = (wr_ptr_r ^ rd_ptr_r) == PTR_FULL_XOR;
      assign empty = wr_ptr_r == rd_ptr_r;
      assign push = src.valid && !full && link_on[lk];
      assign pop = release_r[lk] && !empty;
      assign lane_buffer_full[n] = full;

      always_ff @(posedge clk)
      begin
        if (srst)
          sel_r[n] <= SEL_RST;
        else if (wr_map)
          sel_r[n] <= reg_req.wdata[FLD +: SEL_W];
      end

      always_ff @(posedge clk)
      begin
        if (push)
          mem[wr_ptr_r[BUF_AW-1:0]] <= src.data;
      end

      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          wr_ptr_r <= PTR_RST;
          rd_ptr_r <= PTR_RST;
          logical_lane[n] <= '0;
        end
        else
        begin
          if (push)
            wr_ptr_r <= wr_ptr_r + PTR_ONE;
          if (pop)
            rd_ptr_r <= rd_ptr_r + PTR_ONE;
          logical_lane[n].valid <= pop;
          logical_lane[n].data <= pop ? mem[rd_ptr_r[BUF_AW-1:0]] : logical_lane[n].data;
        end
      end
    end

    for (n = 0; n < LANES/2; n++)
    begin : g_map_rd
      assign map_rd[n] = (reg_req.addr == OFF_MAP[n]) ? {RSV2, sel_r[2*n+1], sel_r[2*n]} : RD_NONE;
    end
  endgenerate

  assign rd_map = map_rd[0] | map_rd[1] | map_rd[2] | map_rd[3];
  assign rd_mux = (reg_req.addr == OFF_FULL) ? lane_buffer_full : (rd_link[0] | rd_link[1] | rd_map);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reg_rdata <= RD_NONE;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      reg_rdata <= reg_req.rd ? rd_mux : reg_rdata;
    end
  end

endmodule
`default_nettype wire

// >>> tb/lxb_lane_src.sv
// lane transmitter model driving the physical lanes
`timescale 1ns/1ps
`default_nettype none
module lxb_lane_src
  import lxb_pkg::*;
(
  // clock
  input wire logic clk,
  // lanes
  output lxb_lane_t serial_input_lane [LANES]
);
  initial
    foreach (serial_input_lane[i])
      serial_input_lane[i] = '0;
  // an idle lane shows inverted data so a stale word never matches
  task automatic send(input int ln, input logic [LANE_W-1:0] w, input int n);
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk);
      serial_input_lane[ln] = '{1'b1, w + LANE_W'(k)};
    end
    @(negedge clk);
    serial_input_lane[ln] = '{1'b0, ~serial_input_lane[ln].data};
  endtask
endmodule
`default_nettype wire

// >>> tb/lxb_top_monitor.sv
// checker for the register port and the full flags
`timescale 1ns/1ps
`default_nettype none
module lxb_top_monitor
  import lxb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // observed ports
  input wire lxb_reg_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [LANES-1:0] lane_buffer_full
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire logic rd_full = reg_req.rd && reg_req.addr == OFF_FULL;
  wire logic rd_narrow = reg_req.rd && reg_req.addr inside {[10'h302:10'h307]};
  wire logic rd_map = reg_req.rd && reg_req.addr inside {[10'h308:10'h30b]};
  wire logic rd_none = reg_req.rd && !(reg_req.addr inside {[10'h302:10'h30c]});
  rvalid_on_read_a: assert property (reg_req.rd |=> reg_rvalid) else $error("rvalid missing");
  rvalid_no_read_a: assert property (!reg_req.rd |=> !reg_rvalid) else $error("rvalid stray");
  rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("rdata moved");
  field_reserved_a: assert property (rd_narrow |=> reg_rdata[7:5] == RSV3) else $error("bits 7:5");
  map_reserved_a: assert property (rd_map |=> reg_rdata[7:6] == RSV2) else $error("bits 7:6");
  full_live_a: assert property (rd_full |=> reg_rdata == $past(lane_buffer_full)) else $error("full read");
  unmapped_zero_a: assert property (rd_none |=> reg_rdata == RD_NONE) else $error("unmapped");
  reset_clear_a: assert property ($fell(srst) |-> lane_buffer_full == '0 && !reg_rvalid)
    else $error("reset state");
endmodule
`default_nettype wire

// >>> tb/tb_lxb_top.sv
// bench: register map, crossbar, full flags and lmfc release
`timescale 1ns/1ps
`default_nettype none
module tb_lxb_top
  import lxb_pkg::*;
;
  logic clk = 0;
  logic srst = 1;
  lxb_reg_req_t reg_req = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic two_link_select = 0;
  logic global_lmfc = 0;
  logic [LINKS-1:0] deframer_lmfc = '0;
  lxb_lane_t serial_input_lane [LANES];
  lxb_lane_t logical_lane [LANES];
  logic [LANES-1:0] lane_buffer_full;
  int failures = 0;
  int check_count = 0;
  lxb_top dut_u (.clk, .srst, .reg_req, .reg_rdata, .reg_rvalid, .two_link_select, .global_lmfc, .deframer_lmfc,
    .serial_input_lane, .logical_lane, .lane_buffer_full);
  lxb_lane_src src_u (.clk, .serial_input_lane);
  initial
    forever #2.5 clk = ~clk;
  task automatic tally_and_finish;
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic reg_op(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    @(negedge clk);
    reg_req = '{a, w, !w, d};
    @(negedge clk);
    reg_req = '0;
  endtask
  task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_op(a, 1'b0, 8'h00);
    for (int i = 0; i < 3 && reg_rvalid !== 1'b1; i++)
      @(negedge clk);
    if (reg_rvalid !== 1'b1)
    begin
      failures++;
      tally_and_finish;
    end
    check($sformatf("reg %h", a), e, reg_rdata);
  endtask
  task automatic do_reset;
    srst = 1;
    repeat (5) @(negedge clk);
    srst = 0;
  endtask
  task automatic map_test;
    logic [DATA_W-1:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h06, 8'h08, 8'h1a, 8'h2c, 8'h3e, 8'h00};
    do_reset;
    for (int i = 0; i < 11; i++)
      reg_check(10'h302 + ADDR_W'(i), rv[i]);
    for (int i = 0; i < 11; i++)
      reg_op(10'h302 + ADDR_W'(i), 1'b1, 8'hea);
    for (int i = 0; i < 11; i++)
      reg_check(10'h302 + ADDR_W'(i), i < 2 || i == 10 ? 8'h00 : i < 6 ? 8'h0a : 8'h2a);
    reg_check(10'h3ff, 8'h00);
  endtask
  task automatic release_test(input int d, input int r, input logic two);
    int first = -1;
    int k = 0;
    do_reset;
    two_link_select = two;
    reg_op(OFF_DELAY[0], 1'b1, 8'(d));
    reg_op(OFF_DELAY[1], 1'b1, 8'(d));
    reg_op(OFF_READOUT[0], 1'b1, 8'(r));
    reg_op(OFF_MAP[0], 1'b1, 8'h0a);
    src_u.send(2, 32'h100, 9);
    check("full", 8'h05, lane_buffer_full);
    @(negedge clk);
    global_lmfc = 1;
    for (int n = 0; n < 60; n++)
    begin
      @(negedge clk);
      global_lmfc = 0;
      deframer_lmfc = n == d + 2 ? 2'b11 : 2'b00;
      if (logical_lane[0].valid === 1'b1)
      begin
        first = first < 0 ? n : first;
        check("word", 32'h100 + k, logical_lane[0].data);
        check("lane2 word", 32'h100 + k, logical_lane[2].data);
        k++;
      end
      check("lane2 valid", n >= d + r + 2 && n < d + r + 10, logical_lane[2].valid);
      check("lane1 valid", 0, logical_lane[1].valid);
    end
    check("first", d + r + 2, first);
    check("words", 8, k);
    reg_check(OFF_FULL, 8'h00);
    reg_check(OFF_LATENCY[0], 8'h03);
    reg_check(OFF_LATENCY[1], two ? 8'h03 : 8'h00);
  endtask
  initial
  begin
    map_test;
    release_test(0, 6, 1'b0);
    release_test(31, 10, 1'b1);
    tally_and_finish;
  end
endmodule
bind lxb_top lxb_top_monitor mon_u (.clk, .srst, .reg_req, .reg_rdata, .reg_rvalid, .lane_buffer_full);
`default_nettype wire
